// ===== core/dsp_port_host.sv
`timescale 1ns/1ps
module dsp_port_host #(
	parameter int POWERUP_CYCLES = pin_mux_pkg::POWERUP_CYCLES
) (
	input  wire logic       clk_in,
	input  wire logic       srst_in,
	dsp_port_if.dsp         port,
	input  wire logic [2:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	output logic      [7:0] reg_rdata_out
);
	pin_mux_pkg::host_state_t state_q;
	logic [15:0] addr_q;
	logic [7:0]  wdata_q;
	logic [7:0]  rdata_q;
	logic        boot_q;
	logic        release_q;
	logic        done_q;
	logic [15:0] hold_cnt_q;
	logic        rst_n_q;
	logic        go;

	assign go = reg_wr_in && reg_addr_in == pin_mux_pkg::HOFS_CTRL && reg_wdata_in[pin_mux_pkg::CTRL_GO];

	// ------------------------------------------------------------------
	// reset to the memory: low from power-up until hold done and released
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			hold_cnt_q <= 16'h0000;
			rst_n_q    <= 1'b0;
		end else begin
			if (hold_cnt_q != 16'(POWERUP_CYCLES))
				hold_cnt_q <= hold_cnt_q + 16'h0001;
			rst_n_q <= release_q && hold_cnt_q == 16'(POWERUP_CYCLES);
		end
	end

	// register file writes
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			addr_q    <= 16'h0000;
			wdata_q   <= 8'h00;
			boot_q    <= 1'b0;
			release_q <= 1'b0;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				pin_mux_pkg::HOFS_CTRL: begin
					boot_q    <= reg_wdata_in[pin_mux_pkg::CTRL_BOOT];
					release_q <= reg_wdata_in[pin_mux_pkg::CTRL_RESET];
				end
				pin_mux_pkg::HOFS_ADDR:  addr_q  <= {8'h00, reg_wdata_in};
				pin_mux_pkg::HOFS_WDATA: wdata_q <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// bus cycle sequencer; a go while busy is ignored
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_q <= pin_mux_pkg::H_IDLE;
		end else begin
			case (state_q)
				pin_mux_pkg::H_IDLE: begin
					if (go && rst_n_q)
						state_q <= reg_wdata_in[pin_mux_pkg::CTRL_READ] ? pin_mux_pkg::H_READ1 : pin_mux_pkg::H_WRITE;
				end
				pin_mux_pkg::H_READ1: state_q <= pin_mux_pkg::H_READ2;
				default:              state_q <= pin_mux_pkg::H_IDLE;
			endcase
		end
	end

	// read capture and done flag; a new go wins over nothing, done clears on go
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rdata_q <= 8'h00;
			done_q  <= 1'b0;
		end else begin
			if (state_q == pin_mux_pkg::H_READ2)
				rdata_q <= port.data_bus;
			if (state_q == pin_mux_pkg::H_READ2 || state_q == pin_mux_pkg::H_WRITE)
				done_q <= 1'b1;
			else if (go)
				done_q <= 1'b0;
		end
	end

	// user read data one cycle after the strobe
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				pin_mux_pkg::HOFS_CTRL:   reg_rdata_out <= {4'h0, release_q, boot_q, 2'h0};
				pin_mux_pkg::HOFS_ADDR:   reg_rdata_out <= addr_q[7:0];
				pin_mux_pkg::HOFS_WDATA:  reg_rdata_out <= wdata_q;
				pin_mux_pkg::HOFS_RDATA:  reg_rdata_out <= rdata_q;
				pin_mux_pkg::HOFS_STATUS: reg_rdata_out <= {5'h00, rst_n_q, done_q, state_q != pin_mux_pkg::H_IDLE};
				default:                  reg_rdata_out <= 8'h00;
			endcase
		end else begin
			reg_rdata_out <= 8'h00;
		end
	end

	// strobes are active low; the select picks boot or control space
	assign port.rd_n       = !(state_q == pin_mux_pkg::H_READ1 || state_q == pin_mux_pkg::H_READ2);
	assign port.wr_n       = !(state_q == pin_mux_pkg::H_WRITE);
	assign port.boot_sel_n = !(state_q != pin_mux_pkg::H_IDLE && boot_q);
	assign port.io_sel_n   = !(state_q != pin_mux_pkg::H_IDLE && !boot_q);
	assign port.rst_n      = rst_n_q;
	assign port.addr       = addr_q;
	assign port.host_data  = wdata_q;
	assign port.host_oe_n  = !(state_q == pin_mux_pkg::H_WRITE);
endmodule

// ===== core/dsp_port_if.sv
`timescale 1ns/1ps
interface dsp_port_if #(parameter int ADDR_W = 16);
	logic              rd_n;
	logic              wr_n;
	logic              boot_sel_n;
	logic              io_sel_n;
	logic              rst_n;
	logic [ADDR_W-1:0] addr;
	logic [7:0]        host_data;
	logic              host_oe_n;
	logic [7:0]        dev_data;
	logic              dev_oe_n;
	wire  [7:0]        data_bus;

	// resolved upper byte of the data bus; idle bus floats high (pull-up)
	assign data_bus = !dev_oe_n ? dev_data : (!host_oe_n ? host_data : 8'hFF);

	modport dsp (output rd_n, wr_n, boot_sel_n, io_sel_n, rst_n, addr, host_data, host_oe_n,
	             input data_bus);
	modport mem (input rd_n, wr_n, boot_sel_n, io_sel_n, rst_n, addr, data_bus,
	             output dev_data, dev_oe_n);
endinterface

// ===== core/dsp_port_pins.sv
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
// Functional notes
// - dsp drives read strobe low to read
// - dsp drives write strobe low to write
// - boot select low qualifies boot-space access
// - reset clears port state and configuration
// - reset held low through power-up
// - all run-time registers clear to zero
// - data port is dsp data bits 8-15
// - second port: io, macrocell out, pld in
// - second port pins 0-3 slew selectable
// - second port pins 3-7 open-drain selectable
// - third port: io, macrocell out, pld in
// - third port 0,1,5,6 carry jtag basics
// - third port 3,4 carry jtag status, error
// - third port 3 may show ready/busy
// - third port io pins open-drain selectable
// - fourth port: io, direct pld in, chip-select
// - chip-select output uses no macrocell
// - fourth port 1 may be pld clock
// - fourth port 2 may gate flash select
// - io memory select routed to pld input; not done here, io_sel_n only gates register access
// - address line 16 routed to pld input; not done here, the address has bits 0-15 only and no pld route
module dsp_port_pins #(
	parameter logic [15:0] P2_FUNC   = 16'h0000, // two bits per pin, FUNC_* codes
	parameter logic [15:0] P3_FUNC   = 16'h0000,
	parameter logic [5:0]  P4_FUNC   = 6'h00,
	parameter bit          P3_RB_PIN = 1'b0      // pin 3 alternate is ready/busy, not jtag status
) (
	input  wire logic       clk_in,
	input  wire logic       srst_in,
	dsp_port_if.mem         port,
	input  wire logic [7:0] p2_pin_in,
	output logic      [7:0] p2_pin_out,
	output logic      [7:0] p2_pin_oe_n_out,
	output logic      [3:0] p2_fast_slew_out,
	input  wire logic [7:0] p3_pin_in,
	output logic      [7:0] p3_pin_out,
	output logic      [7:0] p3_pin_oe_n_out,
	input  wire logic [2:0] p4_pin_in,
	output logic      [2:0] p4_pin_out,
	output logic      [2:0] p4_pin_oe_n_out,
	input  wire logic [7:0] output_macrocells_first_group_in,
	input  wire logic [7:0] output_macrocells_second_group_in,
	input  wire logic [2:0] chip_select_in,
	output logic      [7:0] p2_pld_in_out,
	output logic      [7:0] p3_pld_in_out,
	output logic      [2:0] p4_pld_in_out,
	output logic            pld_common_clock_out,
	output logic            jtag_tms_out,
	output logic            jtag_tck_out,
	output logic            jtag_tdi_out,
	input  wire logic       jtag_tdo_in,
	input  wire logic       jtag_status_signal_in,
	input  wire logic       jtag_error_signal_in,
	input  wire logic       flash_busy_in,
	input  wire logic [7:0] flash_rdata_in,
	output logic            flash_sel_out,
	output logic            flash_rd_out,
	output logic            flash_wr_out,
	output logic      [7:0] flash_wdata_out
);
	// ------------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------------
	function automatic logic [1:0] func_of(input logic [15:0] map, input int idx);
		return map[idx*2 +: 2];
	endfunction

	logic       cfg_rst;
	logic       io_wr;
	logic       io_rd;
	logic       boot_rd;
	logic       flash_en;
	logic [7:0] p2_out_q, p2_dir_q, p2_slew_q, p2_od_q;
	logic [7:0] p3_out_q, p3_dir_q, p3_od_q;
	logic [2:0] p4_out_q, p4_dir_q;
	logic [7:0] rd_mux;
	logic [7:0] dev_data_q;
	logic       dev_oe_n_q;
	logic [7:0] p3_jtag_out;
	logic [7:0] p3_jtag_is_out;

	assign cfg_rst = srst_in || !port.rst_n;
	assign io_wr   = !port.io_sel_n && !port.wr_n && port.boot_sel_n;
	assign io_rd   = !port.io_sel_n && !port.rd_n && port.boot_sel_n;
	assign boot_rd = !port.boot_sel_n && !port.rd_n;

	// flash is disabled while the chip-select input on pin 2 is high
	assign flash_en        = (func_of({10'h000, P4_FUNC}, 2) == pin_mux_pkg::FUNC_ALT) ? !p4_pin_in[2] : 1'b1;
	assign flash_sel_out   = !port.boot_sel_n && flash_en;
	assign flash_rd_out    = flash_sel_out && !port.rd_n;
	assign flash_wr_out    = flash_sel_out && !port.wr_n;
	assign flash_wdata_out = port.data_bus;

	// ------------------------------------------------------------------
	// run-time registers: only drive type and io values are writable
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (cfg_rst) begin
			p2_out_q  <= pin_mux_pkg::REG_RESET;
			p2_dir_q  <= pin_mux_pkg::REG_RESET;
			p2_slew_q <= pin_mux_pkg::REG_RESET;
			p2_od_q   <= pin_mux_pkg::REG_RESET;
			p3_out_q  <= pin_mux_pkg::REG_RESET;
			p3_dir_q  <= pin_mux_pkg::REG_RESET;
			p3_od_q   <= pin_mux_pkg::REG_RESET;
			p4_out_q  <= 3'h0;
			p4_dir_q  <= 3'h0;
		end else if (io_wr) begin
			case (port.addr[7:0])
				pin_mux_pkg::OFS_P2_OUT:  p2_out_q  <= port.data_bus;
				pin_mux_pkg::OFS_P2_DIR:  p2_dir_q  <= port.data_bus;
				pin_mux_pkg::OFS_P2_SLEW: p2_slew_q <= port.data_bus & pin_mux_pkg::P2_SLEW_MASK;
				pin_mux_pkg::OFS_P2_OD:   p2_od_q   <= port.data_bus & pin_mux_pkg::P2_OD_MASK;
				pin_mux_pkg::OFS_P3_OUT:  p3_out_q  <= port.data_bus;
				pin_mux_pkg::OFS_P3_DIR:  p3_dir_q  <= port.data_bus;
				pin_mux_pkg::OFS_P3_OD:   p3_od_q   <= port.data_bus;
				pin_mux_pkg::OFS_P4_OUT:  p4_out_q  <= port.data_bus[2:0];
				pin_mux_pkg::OFS_P4_DIR:  p4_dir_q  <= port.data_bus[2:0];
				default: ; // unused locations are not writable
			endcase
		end
	end

	// read mux: pin registers always show the live pin level
	always_comb begin
		case (port.addr[7:0])
			pin_mux_pkg::OFS_P2_OUT:  rd_mux = p2_out_q;
			pin_mux_pkg::OFS_P2_DIR:  rd_mux = p2_dir_q;
			pin_mux_pkg::OFS_P2_SLEW: rd_mux = p2_slew_q;
			pin_mux_pkg::OFS_P2_OD:   rd_mux = p2_od_q;
			pin_mux_pkg::OFS_P3_OUT:  rd_mux = p3_out_q;
			pin_mux_pkg::OFS_P3_DIR:  rd_mux = p3_dir_q;
			pin_mux_pkg::OFS_P3_OD:   rd_mux = p3_od_q;
			pin_mux_pkg::OFS_P4_OUT:  rd_mux = {5'h00, p4_out_q};
			pin_mux_pkg::OFS_P4_DIR:  rd_mux = {5'h00, p4_dir_q};
			pin_mux_pkg::OFS_P2_PIN:  rd_mux = p2_pin_in;
			pin_mux_pkg::OFS_P3_PIN:  rd_mux = p3_pin_in;
			pin_mux_pkg::OFS_P4_PIN:  rd_mux = {5'h00, p4_pin_in};
			pin_mux_pkg::OFS_STATUS:  rd_mux = {7'h00, flash_busy_in};
			default:                  rd_mux = 8'h00;
		endcase
	end

	// ------------------------------------------------------------------
	// data bus drive: registered, so data lags the first strobe cycle
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			dev_data_q <= 8'h00;
			dev_oe_n_q <= 1'b1;
		end else begin
			dev_data_q <= boot_rd ? flash_rdata_in : rd_mux;
			dev_oe_n_q <= !(io_rd || (boot_rd && flash_en));
		end
	end
	assign port.dev_data = dev_data_q;
	assign port.dev_oe_n = dev_oe_n_q;

	// ------------------------------------------------------------------
	// second port: io, macrocell output or pld input per pin
	// ------------------------------------------------------------------
	assign p2_fast_slew_out = p2_slew_q[3:0];
	assign p2_pld_in_out    = p2_pin_in;
	assign p3_pld_in_out    = p3_pin_in;
	assign p4_pld_in_out    = p4_pin_in;

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_p2
			always_comb begin
				case (func_of(P2_FUNC, i))
					pin_mux_pkg::FUNC_IO: begin
						p2_pin_out[i]      = p2_out_q[i];
						// open drain only pulls low, releases for a one
						p2_pin_oe_n_out[i] = !(p2_dir_q[i] && !(p2_od_q[i] && p2_out_q[i]));
					end
					pin_mux_pkg::FUNC_MCELL: begin
						p2_pin_out[i]      = output_macrocells_first_group_in[i];
						p2_pin_oe_n_out[i] = 1'b0;
					end
					default: begin
						p2_pin_out[i]      = 1'b0;
						p2_pin_oe_n_out[i] = 1'b1;
					end
				endcase
			end
		end

		// third port: jtag pins and ready/busy as alternates
		for (i = 0; i < 8; i++) begin : g_p3
			assign p3_jtag_is_out[i] = (i == 6) || (i == 3) || (i == 4);
			assign p3_jtag_out[i]    = (i == 6) ? jtag_tdo_in :
			                           (i == 4) ? jtag_error_signal_in :
			                           (i == 3) ? (P3_RB_PIN ? !flash_busy_in : jtag_status_signal_in) : 1'b0;
			always_comb begin
				case (func_of(P3_FUNC, i))
					pin_mux_pkg::FUNC_IO: begin
						p3_pin_out[i]      = p3_out_q[i];
						p3_pin_oe_n_out[i] = !(p3_dir_q[i] && !(p3_od_q[i] && p3_out_q[i]));
					end
					pin_mux_pkg::FUNC_MCELL: begin
						p3_pin_out[i]      = output_macrocells_second_group_in[i];
						p3_pin_oe_n_out[i] = 1'b0;
					end
					pin_mux_pkg::FUNC_ALT: begin
						p3_pin_out[i]      = p3_jtag_out[i];
						p3_pin_oe_n_out[i] = !p3_jtag_is_out[i];
					end
					default: begin
						p3_pin_out[i]      = 1'b0;
						p3_pin_oe_n_out[i] = 1'b1;
					end
				endcase
			end
		end

		// fourth port: chip-select taken straight from pld, no macrocell
		for (i = 0; i < 3; i++) begin : g_p4
			always_comb begin
				case (func_of({10'h000, P4_FUNC}, i))
					pin_mux_pkg::FUNC_IO: begin
						p4_pin_out[i]      = p4_out_q[i];
						p4_pin_oe_n_out[i] = !p4_dir_q[i];
					end
					pin_mux_pkg::FUNC_MCELL: begin
						p4_pin_out[i]      = chip_select_in[i];
						p4_pin_oe_n_out[i] = 1'b0;
					end
					default: begin
						p4_pin_out[i]      = 1'b0;
						p4_pin_oe_n_out[i] = 1'b1;
					end
				endcase
			end
		end
	endgenerate

	// jtag inputs pass only when the pin carries the jtag alternate
	assign jtag_tms_out = func_of(P3_FUNC, 0) == pin_mux_pkg::FUNC_ALT && p3_pin_in[0];
	assign jtag_tck_out = func_of(P3_FUNC, 1) == pin_mux_pkg::FUNC_ALT && p3_pin_in[1];
	assign jtag_tdi_out = func_of(P3_FUNC, 5) == pin_mux_pkg::FUNC_ALT && p3_pin_in[5];
	// a gated input here; the pld treats it as its clock source
	assign pld_common_clock_out = func_of({10'h000, P4_FUNC}, 1) == pin_mux_pkg::FUNC_ALT && p4_pin_in[1];
endmodule

// ===== core/pin_mux_pkg.sv
package pin_mux_pkg;
	// --------------------------------------------------------------------
	// static pin functions (fixed by non-volatile configuration)
	// --------------------------------------------------------------------
	localparam logic [1:0] FUNC_IO    = 2'h0;
	localparam logic [1:0] FUNC_MCELL = 2'h1;
	localparam logic [1:0] FUNC_PLDIN = 2'h2;
	localparam logic [1:0] FUNC_ALT   = 2'h3;

	// --------------------------------------------------------------------
	// run-time register offsets inside the control block (device side)
	// --------------------------------------------------------------------
	localparam logic [7:0] OFS_P2_OUT  = 8'h00;
	localparam logic [7:0] OFS_P2_DIR  = 8'h01;
	localparam logic [7:0] OFS_P2_SLEW = 8'h02;
	localparam logic [7:0] OFS_P2_OD   = 8'h03;
	localparam logic [7:0] OFS_P3_OUT  = 8'h04;
	localparam logic [7:0] OFS_P3_DIR  = 8'h05;
	localparam logic [7:0] OFS_P3_OD   = 8'h06;
	localparam logic [7:0] OFS_P4_OUT  = 8'h07;
	localparam logic [7:0] OFS_P4_DIR  = 8'h08;
	localparam logic [7:0] OFS_P2_PIN  = 8'h10;
	localparam logic [7:0] OFS_P3_PIN  = 8'h11;
	localparam logic [7:0] OFS_P4_PIN  = 8'h12;
	localparam logic [7:0] OFS_STATUS  = 8'h13;
	localparam logic [7:0] REG_RESET   = 8'h00;
	// writable bit masks: slew only on pins 0..3, open drain only on 3..7
	localparam logic [7:0] P2_SLEW_MASK = 8'h0F;
	localparam logic [7:0] P2_OD_MASK   = 8'hF8;

	// --------------------------------------------------------------------
	// controller register offsets (user port of the DSP end)
	// --------------------------------------------------------------------
	localparam logic [2:0] HOFS_CTRL   = 3'h0;
	localparam logic [2:0] HOFS_ADDR   = 3'h1;
	localparam logic [2:0] HOFS_WDATA  = 3'h2;
	localparam logic [2:0] HOFS_RDATA  = 3'h3;
	localparam logic [2:0] HOFS_STATUS = 3'h4;
	localparam int CTRL_GO    = 0;
	localparam int CTRL_READ  = 1;
	localparam int CTRL_BOOT  = 2;
	localparam int CTRL_RESET = 3;

	// --------------------------------------------------------------------
	// timing: reset held low after power-up before release is allowed
	// --------------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 10;
	localparam int POWERUP_HOLD_NS = 1000;
	localparam int POWERUP_CYCLES  = (POWERUP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum {H_IDLE, H_WRITE, H_READ1, H_READ2} host_state_t;
endpackage

// ===== verification/dsp_port_assertions.sv
`timescale 1ns/1ps
module dsp_port_assertions (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic boot_sel_n,
	input wire logic io_sel_n,
	input wire logic rst_n,
	input wire logic host_oe_n,
	input wire logic dev_oe_n
);
	// --------------------------------------------------------------------
	// link protocol between the host end and the pin end
	// --------------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	property p_strobe_excl; !(!rd_n && !wr_n); endproperty
	a_strobe_excl: assert property (p_strobe_excl) else $error("read and write strobes low together");
	property p_read_len; $fell(rd_n) |=> !rd_n ##1 rd_n; endproperty
	a_read_len: assert property (p_read_len) else $error("read strobe not two cycles long");
	property p_write_len; $fell(wr_n) |=> wr_n; endproperty
	a_write_len: assert property (p_write_len) else $error("write strobe not one cycle long");
	// device answer window: two cycles of drive, then release
	property p_dev_answer; $fell(rd_n) && !io_sel_n |=> !dev_oe_n[*2] ##1 dev_oe_n; endproperty
	a_dev_answer: assert property (p_dev_answer) else $error("device read drive window wrong");
	property p_bus_excl; !(!dev_oe_n && !host_oe_n); endproperty
	a_bus_excl: assert property (p_bus_excl) else $error("both ends drive the data byte");
	property p_read_host_off; !rd_n |-> host_oe_n; endproperty
	a_read_host_off: assert property (p_read_host_off) else $error("host drives during read");
	property p_select_excl; !(!boot_sel_n && !io_sel_n); endproperty
	a_select_excl: assert property (p_select_excl) else $error("boot and io select low together");
	property p_boot_strobe; !boot_sel_n |-> (!rd_n || !wr_n); endproperty
	a_boot_strobe: assert property (p_boot_strobe) else $error("boot select without a strobe");
	// the reset check must run while reset is high, so no disable here
	property p_reset_hold; @(posedge clk_in) disable iff (1'b0) srst_in |=> !rst_n && rd_n && wr_n; endproperty
	a_reset_hold: assert property (p_reset_hold) else $error("link not quiet after reset");
	property p_no_access_rst; !rst_n |-> rd_n && wr_n; endproperty
	a_no_access_rst: assert property (p_no_access_rst) else $error("access while device reset low");
	property p_dev_quiet_rst; !rst_n |=> dev_oe_n; endproperty
	a_dev_quiet_rst: assert property (p_dev_quiet_rst) else $error("device drives while in reset");

	c_read: cover property ($fell(rd_n) && !io_sel_n ##2 !dev_oe_n);
	c_boot: cover property (!boot_sel_n && !wr_n);
	c_release: cover property ($rose(rst_n));
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic            clk_in, srst_in, reg_wr, reg_rd, rd_seen, tdo, jtag_status_signal, jtag_error_signal, busy;
	logic      [2:0] reg_addr, p4_in, cs;
	logic      [7:0] reg_wdata, p2_in, p3_in, mc1, mc2, frd, v, e, wcap;
	logic      [7:0] r [0:8];
	logic      [7:0] exp_q [$];
	wire logic [7:0] reg_rdata, p2_out, p2_oe_n, p3_out, p3_oe_n, p2_pld, p3_pld, fwdata;
	wire logic [3:0] slew;
	wire logic [2:0] p4_out, p4_oe_n, p4_pld;
	wire logic       pclk, tms, tck, tdi, fsel, fwr, frdo;
	int              num_errors, check_count, i, sel_cnt, base, rcnt;

	dsp_port_if dsp_port_if_inst ();
	dsp_port_host #(.POWERUP_CYCLES(4)) dsp_port_host_inst (.clk_in(clk_in), .srst_in(srst_in),
		.port(dsp_port_if_inst), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
		.reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata));
	dsp_port_pins #(.P2_FUNC(16'h0000), .P3_FUNC(16'h7FCF), .P4_FUNC(6'h3D), .P3_RB_PIN(1'b1)) dsp_port_pins_inst (
		.clk_in(clk_in), .srst_in(srst_in), .port(dsp_port_if_inst), .p2_pin_in(p2_in), .p2_pin_out(p2_out),
		.p2_pin_oe_n_out(p2_oe_n), .p2_fast_slew_out(slew), .p3_pin_in(p3_in), .p3_pin_out(p3_out),
		.p3_pin_oe_n_out(p3_oe_n), .p4_pin_in(p4_in), .p4_pin_out(p4_out), .p4_pin_oe_n_out(p4_oe_n),
		.output_macrocells_first_group_in(mc1), .output_macrocells_second_group_in(mc2), .chip_select_in(cs),
		.p2_pld_in_out(p2_pld), .p3_pld_in_out(p3_pld), .p4_pld_in_out(p4_pld), .pld_common_clock_out(pclk),
		.jtag_tms_out(tms), .jtag_tck_out(tck), .jtag_tdi_out(tdi), .jtag_tdo_in(tdo),
		.jtag_status_signal_in(jtag_status_signal), .jtag_error_signal_in(jtag_error_signal), .flash_busy_in(busy),
		.flash_rdata_in(frd), .flash_sel_out(fsel), .flash_rd_out(frdo), .flash_wr_out(fwr), .flash_wdata_out(fwdata));
	dsp_port_assertions dsp_port_assertions_inst (.clk_in(clk_in), .srst_in(srst_in),
		.rd_n(dsp_port_if_inst.rd_n), .wr_n(dsp_port_if_inst.wr_n), .boot_sel_n(dsp_port_if_inst.boot_sel_n),
		.io_sel_n(dsp_port_if_inst.io_sel_n), .rst_n(dsp_port_if_inst.rst_n),
		.host_oe_n(dsp_port_if_inst.host_oe_n), .dev_oe_n(dsp_port_if_inst.dev_oe_n));

	// --------------------------------------------------------------------
	// clock, watchdog and report
	// --------------------------------------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// the whole sequence needs well under 2000 cycles
	initial begin
		#100000;
		num_errors++;
		close_out();
	end
	task automatic check_rd(input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: expected %h, got %h", $time, exp, got);
		end
	endtask
	task automatic check_pin(input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: expected %h, got %h", $time, exp, got);
		end
	endtask
	task close_out;
		$display("errors %0d, checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// read data stands only in the cycle after the strobe; oldest note first
	always @(posedge clk_in) begin
		if (rd_seen) check_rd(exp_q.pop_front(), reg_rdata);
		rd_seen <= reg_rd;
		if (fwr) wcap <= fwdata;
		if (fsel) sel_cnt <= sel_cnt + 1;
		if (frdo) rcnt <= rcnt + 1;
	end

	// --------------------------------------------------------------------
	// user port cycles and link transfers
	// --------------------------------------------------------------------
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_in);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] x);
		@(posedge clk_in);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(x);
		@(posedge clk_in);
		reg_rd <= 1'b0;
	endtask
	// one transfer ends within four cycles of go, so six is ample
	task automatic xfer(input logic [7:0] ofs, input logic [7:0] d, input logic rdb, input logic boot);
		wr(pin_mux_pkg::HOFS_ADDR, ofs);
		wr(pin_mux_pkg::HOFS_WDATA, d);
		wr(pin_mux_pkg::HOFS_CTRL, {4'h0, 1'b1, boot, rdb, 1'b1});
		repeat (6) @(posedge clk_in);
	endtask
	task automatic dev_rd(input logic [7:0] ofs, input logic [7:0] x);
		xfer(ofs, 8'h00, 1'b1, 1'b0);
		rd(pin_mux_pkg::HOFS_RDATA, x);
	endtask

	// --------------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------------
	initial begin
		v = 8'($urandom(32'h88C03FA1));
		{srst_in, reg_wr, reg_rd, rd_seen, tdo, jtag_status_signal, jtag_error_signal, busy} = 8'h80;
		{reg_addr, p4_in, cs, reg_wdata, p2_in, p3_in, mc1, mc2, frd, wcap} = '0;
		sel_cnt = 0;
		rcnt = 0;
		repeat (3) @(posedge clk_in);
		srst_in <= 1'b0;
		wr(pin_mux_pkg::HOFS_CTRL, 8'h01);
		rd(pin_mux_pkg::HOFS_STATUS, 8'h00);
		wr(pin_mux_pkg::HOFS_CTRL, 8'h08);
		repeat (8) @(posedge clk_in);
		rd(pin_mux_pkg::HOFS_STATUS, 8'h04);
		for (i = 0; i < 9; i++) dev_rd(i[7:0], pin_mux_pkg::REG_RESET);
		// random values through every run-time register, masks applied
		for (i = 0; i < 9; i++) begin
			v = 8'($urandom);
			xfer(i[7:0], v, 1'b0, 1'b0);
			r[i] = (i == 2) ? (v & pin_mux_pkg::P2_SLEW_MASK) : ((i == 3) ? (v & pin_mux_pkg::P2_OD_MASK) : v);
			// port four has only three pins, so its registers keep three bits
			if (i > 6) r[i] = v & 8'h07;
			dev_rd(i[7:0], r[i]);
		end
		rd(pin_mux_pkg::HOFS_STATUS, 8'h06);
		e = ~(r[1] & (~r[3] | ~r[0]));
		check_pin({4'h0, r[2][3:0]}, {4'h0, slew});
		check_pin(e, p2_oe_n);
		check_pin(r[0] | e, p2_out | p2_oe_n);
		check_pin({7'h0, ~(r[5][2] & (~r[6][2] | ~r[4][2]))}, {7'h0, p3_oe_n[2]});
		// random pin and core inputs, then alternates and read-back
		@(posedge clk_in);
		{p2_in, p3_in, mc1, mc2, frd} <= {$urandom, 8'($urandom)};
		{p4_in, cs, tdo, jtag_status_signal, jtag_error_signal, busy} <= 10'($urandom);
		@(posedge clk_in);
		check_pin({6'h0, 1'b0, cs[0]}, {6'h0, p4_oe_n[0], p4_out[0]});
		check_pin({5'h0, p3_in[0], p3_in[1], p3_in[5]}, {5'h0, tms, tck, tdi});
		check_pin({4'h0, mc2[7], tdo, jtag_error_signal, ~busy}, {4'h0, p3_out[7], p3_out[6], p3_out[4], p3_out[3]});
		check_pin({7'h0, p4_in[1]}, {7'h0, pclk});
		check_pin(p2_in, p2_pld);
		check_pin(p3_in, p3_pld);
		check_pin({5'h00, p4_in}, {5'h00, p4_pld});
		dev_rd(pin_mux_pkg::OFS_P2_PIN, p2_in);
		dev_rd(pin_mux_pkg::OFS_STATUS, {7'h0, busy});
		xfer(8'h20, 8'h5A, 1'b0, 1'b0);
		dev_rd(8'h20, 8'h00);
		rd(3'h5, 8'h00);
		// boot write reaches flash only while the chip-select input is low
		p4_in[2] <= 1'b0;
		v = 8'($urandom);
		xfer(8'h40, v, 1'b0, 1'b1);
		check_pin(v, wcap);
		// boot read: flash data comes back through the data byte, two read cycles
		xfer(8'h40, 8'h00, 1'b1, 1'b1);
		rd(pin_mux_pkg::HOFS_RDATA, frd);
		check_pin(8'h02, 8'(rcnt));
		p4_in[2] <= 1'b1;
		@(posedge clk_in);
		base = sel_cnt;
		xfer(8'h41, ~v, 1'b0, 1'b1);
		check_pin(8'h00, 8'(sel_cnt - base));
		// device reset in mid-run clears the port again
		xfer(pin_mux_pkg::OFS_P2_DIR, 8'hA5, 1'b0, 1'b0);
		wr(pin_mux_pkg::HOFS_CTRL, 8'h00);
		repeat (3) @(posedge clk_in);
		check_pin(8'hFF, p2_oe_n);
		wr(pin_mux_pkg::HOFS_CTRL, 8'h08);
		repeat (8) @(posedge clk_in);
		dev_rd(pin_mux_pkg::OFS_P2_DIR, 8'h00);
		repeat (2) @(posedge clk_in);
		close_out();
	end
endmodule
